/* File: calb_exec.sv */
// execution unit for add, and, shift, branch, bit, breakpoint, bounds and compare operations
`timescale 1ns/1ps
`default_nettype none
module calb_exec
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // bus cycle requests toward the core
  output logic push_wr,
  output logic [31:0] push_addr,
  output logic [31:0] push_data,
  output logic dest_wr,
  output logic bp_ack,
  output logic trap,
  output logic [1:0] trap_kind,
  // interrupt
  output logic irq
);

  //----------------------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------------------
  function automatic int msb_pos(input logic [1:0] sz);
    msb_pos = (sz == calb_pkg::SZ_BYTE) ? 7 : (sz == calb_pkg::SZ_WORD) ? 15 : 31;
  endfunction

  function automatic logic [31:0] szmask(input logic [31:0] v, input logic [1:0] sz);
    szmask = (sz == calb_pkg::SZ_BYTE) ? {24'h00_0000, v[7:0]} :
             (sz == calb_pkg::SZ_WORD) ? {16'h0000, v[15:0]} : v;
  endfunction

  // keeps the untouched upper part of the destination for byte and word sizes
  function automatic logic [31:0] merge(input logic [31:0] d, input logic [31:0] r,
                                        input logic [1:0] sz);
    merge = (d & ~szmask(32'hffff_ffff, sz)) | szmask(r, sz);
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[i*8 +: 8] = wd[i*8 +: 8];
    end
    be_merge = r;
  endfunction

  function automatic logic cond_true(input logic [3:0] c, input logic [4:0] cc);
    logic n, z, v, k;
    n = cc[calb_pkg::CC_N];
    z = cc[calb_pkg::CC_Z];
    v = cc[calb_pkg::CC_V];
    k = cc[calb_pkg::CC_C];
    case (c)
      4'h0: cond_true = 1'b1;
      4'h1: cond_true = 1'b0;
      4'h2: cond_true = ~k & ~z;
      4'h3: cond_true = k | z;
      4'h4: cond_true = ~k;
      4'h5: cond_true = k;
      4'h6: cond_true = ~z;
      4'h7: cond_true = z;
      4'h8: cond_true = ~v;
      4'h9: cond_true = v;
      4'ha: cond_true = ~n;
      4'hb: cond_true = n;
      4'hc: cond_true = ~(n ^ v);
      4'hd: cond_true = n ^ v;
      4'he: cond_true = ~z & ~(n ^ v);
      default: cond_true = z | (n ^ v);
    endcase
  endfunction

  //----------------------------------------------------------------------------
  // registers and command decode
  //----------------------------------------------------------------------------
  logic [31:0] cmd_q, src_q, dst_q, pc_q, sp_q, result_q;
  logic [15:0] sr_q;
  logic [calb_pkg::IRQ_W-1:0] irq_st_q, irq_mask_q;
  logic dwr_last_q, taken_q;
  logic [1:0] trap_last_q;
  calb_pkg::calb_state_t state_q;

  calb_pkg::calb_op_t op;
  logic [1:0] size;
  logic [3:0] cond;
  logic cnt_reg, mem_op;
  assign op = calb_pkg::calb_op_t'(cmd_q[calb_pkg::CMD_OP_LSB +: 5]);
  assign size = cmd_q[calb_pkg::CMD_SIZE_LSB +: 2];
  assign cond = cmd_q[calb_pkg::CMD_COND_LSB +: 4];
  assign cnt_reg = cmd_q[calb_pkg::CMD_CNT_REG_BIT];
  assign mem_op = cmd_q[calb_pkg::CMD_MEM_BIT];

  // the status register is only half a bus word wide
  logic [31:0] sr_wr;
  assign sr_wr = be_merge({16'h0000, sr_q}, avs_writedata, avs_byteenable);

  // a bus access completes on the edge where waitrequest is seen low
  logic acc_done, wr_done, cmd_start, exec;
  assign acc_done = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr_done = avs_write & ~avs_waitrequest;
  assign cmd_start = wr_done & (avs_address == calb_pkg::OFS_CMD) & avs_byteenable[0]
                     & (state_q == calb_pkg::ST_IDLE);
  assign exec = (state_q == calb_pkg::ST_EXEC);

  //----------------------------------------------------------------------------
  // operation datapath
  //----------------------------------------------------------------------------
  logic [31:0] res, pc_n, sp_n;
  logic [15:0] sr_n;
  logic [4:0] cc;
  logic dwr, push, bp_hit, take, trp;
  logic [1:0] tkind;

  always_comb
  begin
    logic [31:0] a, b, r, v;
    logic [32:0] sum;
    logic [5:0] cnt, bn;
    logic c, vf, sb;
    int m;
    a = szmask(src_q, size);
    b = szmask(dst_q, size);
    m = msb_pos(size);
    r = 32'h0000_0000;
    v = b;
    sum = 33'h0_0000_0000;
    cnt = 6'h00;
    bn = 6'h00;
    c = 1'b0;
    vf = 1'b0;
    sb = 1'b0;
    res = dst_q;
    pc_n = pc_q;
    sp_n = sp_q;
    sr_n = sr_q;
    cc = sr_q[4:0];
    dwr = 1'b0;
    push = 1'b0;
    bp_hit = 1'b0;
    take = 1'b0;
    trp = 1'b0;
    tkind = calb_pkg::TRAP_NONE;
    case (op)
      calb_pkg::OP_ADD_IMM, calb_pkg::OP_ADD_QUICK, calb_pkg::OP_ADD_X:
      begin
        // quick data of zero stands for eight
        if (op == calb_pkg::OP_ADD_QUICK)
          a = (src_q[2:0] == 3'h0) ? 32'h0000_0008 : {29'h0000_0000, src_q[2:0]};
        sum = {1'b0, a} + {1'b0, b};
        if (op == calb_pkg::OP_ADD_X)
          sum = sum + {32'h0000_0000, sr_q[calb_pkg::CC_X]};
        r = szmask(sum[31:0], size);
        c = sum[m+1];
        res = merge(dst_q, r, size);
        dwr = 1'b1;
        cc[calb_pkg::CC_X] = c;
        cc[calb_pkg::CC_C] = c;
        cc[calb_pkg::CC_N] = r[m];
        cc[calb_pkg::CC_V] = (a[m] == b[m]) & (r[m] != b[m]);
        // extended add only clears zero, so multi-word sums keep a valid zero flag
        if (op == calb_pkg::OP_ADD_X)
          cc[calb_pkg::CC_Z] = (r == 32'h0000_0000) & sr_q[calb_pkg::CC_Z];
        else
          cc[calb_pkg::CC_Z] = (r == 32'h0000_0000);
      end
      calb_pkg::OP_AND_IMM:
      begin
        r = a & b;
        res = merge(dst_q, r, size);
        dwr = 1'b1;
        cc[calb_pkg::CC_N] = r[m];
        cc[calb_pkg::CC_Z] = (r == 32'h0000_0000);
        cc[calb_pkg::CC_V] = 1'b0;
        cc[calb_pkg::CC_C] = 1'b0;
      end
      calb_pkg::OP_AND_COND_BYTE:
        cc = sr_q[4:0] & src_q[4:0];
      calb_pkg::OP_AND_SR:
      begin
        if (sr_q[calb_pkg::SR_S_BIT])
        begin
          sr_n = sr_q & src_q[15:0];
          cc = sr_n[4:0];
        end
        else
        begin
          trp = 1'b1;
          tkind = calb_pkg::TRAP_PRIV;
        end
      end
      calb_pkg::OP_ARITH_SHIFT_LEFT, calb_pkg::OP_ARITH_SHIFT_RIGHT:
      begin
        // memory operands always move by exactly one place
        if (mem_op)
          cnt = 6'h01;
        else if (cnt_reg)
          cnt = src_q[5:0];
        else
          cnt = (src_q[2:0] == 3'h0) ? calb_pkg::IMM_CNT_ZERO : {3'h0, src_q[2:0]};
        // unrolled shifter trades area for a single-cycle result
        for (int i = 0; i < 64; i++)
        begin
          if (i < int'(cnt))
          begin
            if (op == calb_pkg::OP_ARITH_SHIFT_LEFT)
            begin
              c = v[m];
              v = szmask({v[30:0], 1'b0}, size);
              if (v[m] != c)
                vf = 1'b1;
            end
            else
            begin
              c = v[0];
              sb = v[m];
              v = {1'b0, v[31:1]};
              v[m] = sb;
            end
          end
        end
        res = merge(dst_q, v, size);
        dwr = 1'b1;
        cc[calb_pkg::CC_N] = v[m];
        cc[calb_pkg::CC_Z] = (v == 32'h0000_0000);
        cc[calb_pkg::CC_V] = vf;
        cc[calb_pkg::CC_C] = (cnt != 6'h00) & c;
        if (cnt != 6'h00)
          cc[calb_pkg::CC_X] = c;
      end
      calb_pkg::OP_BCC:
      begin
        if (cond_true(cond, sr_q[4:0]))
        begin
          pc_n = pc_q + src_q;
          take = 1'b1;
        end
      end
      calb_pkg::OP_BRANCH_TO_SUBROUTINE:
      begin
        sp_n = sp_q - calb_pkg::STACK_STEP;
        push = 1'b1;
        pc_n = pc_q + src_q;
        take = 1'b1;
      end
      calb_pkg::OP_BIT_TEST, calb_pkg::OP_BIT_CHANGE, calb_pkg::OP_BIT_CLEAR, calb_pkg::OP_BIT_SET:
      begin
        // long size numbers bits modulo 32, byte and word sizes modulo 8
        bn = (size == calb_pkg::SZ_LONG) ? {1'b0, src_q[4:0]} : {3'h0, src_q[2:0]};
        cc[calb_pkg::CC_Z] = ~dst_q[bn[4:0]];
        r = dst_q;
        if (op == calb_pkg::OP_BIT_CHANGE)
          r[bn[4:0]] = ~dst_q[bn[4:0]];
        else if (op == calb_pkg::OP_BIT_CLEAR)
          r[bn[4:0]] = 1'b0;
        else if (op == calb_pkg::OP_BIT_SET)
          r[bn[4:0]] = 1'b1;
        res = r;
        dwr = (op != calb_pkg::OP_BIT_TEST);
      end
      calb_pkg::OP_BREAKPOINT_INSTR:
        bp_hit = 1'b1;
      calb_pkg::OP_BOUNDS_CHECK:
      begin
        if ($signed(dst_q[15:0]) < $signed(16'h0000))
        begin
          trp = 1'b1;
          cc[calb_pkg::CC_N] = 1'b1;
        end
        else if ($signed(dst_q[15:0]) > $signed(src_q[15:0]))
        begin
          trp = 1'b1;
          cc[calb_pkg::CC_N] = 1'b0;
        end
        if (trp)
          tkind = calb_pkg::TRAP_BOUNDS;
      end
      calb_pkg::OP_COMPARE:
      begin
        sum = {1'b0, b} - {1'b0, a};
        r = szmask(sum[31:0], size);
        cc[calb_pkg::CC_C] = sum[m+1];
        cc[calb_pkg::CC_N] = r[m];
        cc[calb_pkg::CC_Z] = (r == 32'h0000_0000);
        cc[calb_pkg::CC_V] = (a[m] != b[m]) & (r[m] != b[m]);
        res = r;
      end
      default:
        res = dst_q;
    endcase
  end

  //----------------------------------------------------------------------------
  // sequencer: idle, one execute cycle, optional acknowledge cycle
  //----------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= calb_pkg::ST_IDLE;
    else
      case (state_q)
        calb_pkg::ST_IDLE: if (cmd_start) state_q <= calb_pkg::ST_EXEC;
        calb_pkg::ST_EXEC: state_q <= bp_hit ? calb_pkg::ST_ACK : calb_pkg::ST_IDLE;
        calb_pkg::ST_ACK: state_q <= calb_pkg::ST_IDLE;
        default: state_q <= calb_pkg::ST_IDLE;
      endcase
  end

  // bus-facing pulses; breakpoint acknowledge precedes its illegal trap by one cycle
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      push_wr <= 1'b0;
      push_addr <= 32'h0000_0000;
      push_data <= 32'h0000_0000;
      dest_wr <= 1'b0;
      bp_ack <= 1'b0;
      trap <= 1'b0;
      trap_kind <= calb_pkg::TRAP_NONE;
    end
    else
    begin
      push_wr <= exec & push;
      dest_wr <= exec & dwr;
      bp_ack <= exec & bp_hit;
      trap <= (exec & trp) | (state_q == calb_pkg::ST_ACK);
      if (exec & push)
      begin
        push_addr <= sp_n;
        push_data <= pc_q;
      end
      if (exec & trp)
        trap_kind <= tkind;
      else if (state_q == calb_pkg::ST_ACK)
        trap_kind <= calb_pkg::TRAP_ILLEGAL;
    end
  end

  //----------------------------------------------------------------------------
  // architectural state: execution wins over a same-cycle bus write
  //----------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_q <= 32'h0000_0000;
      src_q <= 32'h0000_0000;
      dst_q <= 32'h0000_0000;
      pc_q <= 32'h0000_0000;
      sp_q <= 32'h0000_0000;
      sr_q <= calb_pkg::SR_RESET;
      result_q <= 32'h0000_0000;
      dwr_last_q <= 1'b0;
      taken_q <= 1'b0;
      trap_last_q <= calb_pkg::TRAP_NONE;
    end
    else if (exec)
    begin
      result_q <= res;
      if (dwr)
        dst_q <= res;
      pc_q <= pc_n;
      sp_q <= sp_n;
      sr_q <= {sr_n[15:5], cc};
      dwr_last_q <= dwr;
      taken_q <= take;
      trap_last_q <= bp_hit ? calb_pkg::TRAP_ILLEGAL : tkind;
    end
    else if (wr_done)
    begin
      case (avs_address)
        calb_pkg::OFS_CMD: cmd_q <= be_merge(cmd_q, avs_writedata, avs_byteenable);
        calb_pkg::OFS_SRC: src_q <= be_merge(src_q, avs_writedata, avs_byteenable);
        calb_pkg::OFS_DST: dst_q <= be_merge(dst_q, avs_writedata, avs_byteenable);
        calb_pkg::OFS_PC: pc_q <= be_merge(pc_q, avs_writedata, avs_byteenable);
        calb_pkg::OFS_SP: sp_q <= be_merge(sp_q, avs_writedata, avs_byteenable);
        calb_pkg::OFS_SR: sr_q <= sr_wr[15:0];
        default: sr_q <= sr_q;
      endcase
    end
  end

  // event and clear vectors of the sticky status; a new event beats the clear
  logic [calb_pkg::IRQ_W-1:0] irq_ev, irq_clr, irq_nxt;
  always_comb
  begin
    irq_ev = '0;
    irq_ev[calb_pkg::IRQ_DONE_BIT] = (exec & ~bp_hit) | (state_q == calb_pkg::ST_ACK);
    irq_ev[calb_pkg::IRQ_TRAP_BIT] = (exec & trp) | (state_q == calb_pkg::ST_ACK);
    irq_ev[calb_pkg::IRQ_BP_BIT] = exec & bp_hit;
    irq_clr = (wr_done && avs_address == calb_pkg::OFS_IRQ_ST && avs_byteenable[0]) ?
              avs_writedata[calb_pkg::IRQ_W-1:0] : '0;
    irq_nxt = (irq_st_q & ~irq_clr) | irq_ev;
  end

  // sticky events, write one to clear
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_st_q <= '0;
      irq_mask_q <= '0;
      irq <= 1'b0;
    end
    else
    begin
      irq_st_q <= irq_nxt;
      if (wr_done && avs_address == calb_pkg::OFS_IRQ_MASK && avs_byteenable[0])
        irq_mask_q <= avs_writedata[calb_pkg::IRQ_W-1:0];
      irq <= |(irq_nxt & irq_mask_q);
    end
  end

  //----------------------------------------------------------------------------
  // avalon slave: one wait cycle per access, read data registered with the ack
  //----------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest & ~acc_done);
      if (avs_read & avs_waitrequest)
        case (avs_address)
          calb_pkg::OFS_CMD: avs_readdata <= cmd_q;
          calb_pkg::OFS_SRC: avs_readdata <= src_q;
          calb_pkg::OFS_DST: avs_readdata <= dst_q;
          calb_pkg::OFS_PC: avs_readdata <= pc_q;
          calb_pkg::OFS_SP: avs_readdata <= sp_q;
          calb_pkg::OFS_SR: avs_readdata <= {16'h0000, sr_q};
          calb_pkg::OFS_RESULT: avs_readdata <= result_q;
          calb_pkg::OFS_STATUS: avs_readdata <= {26'h000_0000, trap_last_q, 1'b0, taken_q,
                                                 dwr_last_q, (state_q != calb_pkg::ST_IDLE)};
          calb_pkg::OFS_IRQ_ST: avs_readdata <= {29'h0000_0000, irq_st_q};
          calb_pkg::OFS_IRQ_MASK: avs_readdata <= {29'h0000_0000, irq_mask_q};
          default: avs_readdata <= 32'h0000_0000;
        endcase
    end
  end

  //----------------------------------------------------------------------------
  // checks
  //----------------------------------------------------------------------------
  logic [31:0] h_add, h_add_with_extend, h_and, h_sp4;
  assign h_add = dst_q + src_q;
  assign h_add_with_extend = dst_q + src_q + {31'h0000_0000, sr_q[calb_pkg::CC_X]};
  assign h_and = dst_q & src_q;
  assign h_sp4 = sp_q - calb_pkg::STACK_STEP;
  logic is_long;
  assign is_long = (size == calb_pkg::SZ_LONG);

  AST_ADD_IMM: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && op == calb_pkg::OP_ADD_IMM && is_long |=> dst_q == $past(h_add) && dest_wr)
    else $error("immediate add result wrong");
  AST_ADD_X: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && op == calb_pkg::OP_ADD_X && is_long |=> result_q == $past(h_add_with_extend))
    else $error("extended add result wrong");
  AST_AND_IMM: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && op == calb_pkg::OP_AND_IMM && is_long |=> dst_q == $past(h_and))
    else $error("immediate and result wrong");
  AST_AND_SR_USER: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && op == calb_pkg::OP_AND_SR && !sr_q[calb_pkg::SR_S_BIT]
    |=> trap && trap_kind == calb_pkg::TRAP_PRIV && $stable(sr_q))
    else $error("user-state status and not trapped");
  AST_BCC_NOT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && op == calb_pkg::OP_BCC && !cond_true(cond, sr_q[4:0]) |=> $stable(pc_q))
    else $error("untaken branch moved the counter");
  AST_SUBROUTINE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && op == calb_pkg::OP_BRANCH_TO_SUBROUTINE
    |=> push_wr && sp_q == $past(h_sp4) && push_addr == sp_q && push_data == $past(pc_q))
    else $error("subroutine branch stack push wrong");
  AST_BIT_TEST: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && op == calb_pkg::OP_BIT_TEST |=> !dest_wr && $stable(dst_q))
    else $error("bit test wrote its operand");
  AST_BIT_SET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && op == calb_pkg::OP_BIT_SET && is_long |=> dst_q[$past(src_q[4:0])] == 1'b1)
    else $error("bit set left bit low");
  AST_BREAKPOINT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && op == calb_pkg::OP_BREAKPOINT_INSTR |=> bp_ack && !trap ##1 trap
    && trap_kind == calb_pkg::TRAP_ILLEGAL)
    else $error("breakpoint sequence wrong");
  AST_BOUNDS_NEG: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && op == calb_pkg::OP_BOUNDS_CHECK && dst_q[15]
    |=> trap && trap_kind == calb_pkg::TRAP_BOUNDS)
    else $error("negative bound check not trapped");
  AST_COMPARE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && op == calb_pkg::OP_COMPARE |=> !dest_wr && $stable(dst_q))
    else $error("compare changed destination");

  COV_SUBROUTINE: cover property (@(posedge ref_clk) disable iff (!rst_n)
    exec && op == calb_pkg::OP_BRANCH_TO_SUBROUTINE ##1 push_wr);
  COV_BREAKPOINT: cover property (@(posedge ref_clk) disable iff (!rst_n)
    bp_ack ##1 trap);
  COV_IRQ: cover property (@(posedge ref_clk) disable iff (!rst_n)
    trap ##[1:3] irq);

endmodule
`default_nettype wire

/* File: calb_pkg.sv */
// constants, types and register map of the arithmetic, logic, bit and branch execution block
//------------------------------------------------------------------------------
// Contract
// - immediate and quick add sum into destination
// - extended add sums source, destination, extend flag
// - immediate and ands constant into destination
// - and into condition byte, any privilege
// - and into status register needs supervisor
// - arithmetic shifts by register, immediate or memory
// - conditional branch adds displacement only when true
// - subroutine branch pushes counter, then branches
// - bit test loads zero flag, no change
// - bit change inverts the selected bit
// - bit clear forces selected bit low
// - bit set forces selected bit high
// - breakpoint runs acknowledge, then illegal trap
// - bounds check traps below zero or above bound
// - compare subtracts to set condition codes and result register, destination unchanged
//------------------------------------------------------------------------------
package calb_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_SRC = 8'h04;
  localparam logic [7:0] OFS_DST = 8'h08;
  localparam logic [7:0] OFS_PC = 8'h0c;
  localparam logic [7:0] OFS_SP = 8'h10;
  localparam logic [7:0] OFS_SR = 8'h14;
  localparam logic [7:0] OFS_RESULT = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_IRQ_ST = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;

  // command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_SIZE_LSB = 8;
  localparam int CMD_COND_LSB = 12;
  localparam int CMD_CNT_REG_BIT = 16;
  localparam int CMD_MEM_BIT = 17;

  // status register and condition byte fields
  localparam int SR_S_BIT = 13;
  localparam int CC_X = 4;
  localparam int CC_N = 3;
  localparam int CC_Z = 2;
  localparam int CC_V = 1;
  localparam int CC_C = 0;
  localparam logic [15:0] SR_RESET = 16'h2000;

  // status word fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DWR_BIT = 1;
  localparam int ST_TAKEN_BIT = 2;
  localparam int ST_TRAP_LSB = 4;

  // interrupt status bits
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_TRAP_BIT = 1;
  localparam int IRQ_BP_BIT = 2;
  localparam int IRQ_W = 3;

  localparam logic [31:0] STACK_STEP = 32'h0000_0004;
  localparam logic [5:0] IMM_CNT_ZERO = 6'h08;

  typedef enum logic [4:0] {
    OP_ADD_IMM, OP_ADD_QUICK, OP_ADD_X, OP_AND_IMM, OP_AND_COND_BYTE, OP_AND_SR,
    OP_ARITH_SHIFT_LEFT, OP_ARITH_SHIFT_RIGHT, OP_BCC, OP_BRANCH_TO_SUBROUTINE,
    OP_BIT_TEST, OP_BIT_CHANGE, OP_BIT_CLEAR, OP_BIT_SET,
    OP_BREAKPOINT_INSTR, OP_BOUNDS_CHECK, OP_COMPARE
  } calb_op_t;

  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} calb_size_t;

  typedef enum logic [1:0] {TRAP_NONE, TRAP_PRIV, TRAP_BOUNDS, TRAP_ILLEGAL} calb_trap_t;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_ACK} calb_state_t;

endpackage

/* File: calb_exec_test.sv */
// self-checking bench for the execution block, driven over its register bus
`timescale 1ns/1ps
`default_nettype none
module calb_exec_test;
  //----------------------------------------------------------------
  // signals, counters and the block under test
  //----------------------------------------------------------------
  logic ref_clk, rst_n, rd_q, wr_q;
  logic [7:0] a_q;
  logic [31:0] wd_q, rdat;
  wire logic [31:0] rdata, paddr, pdata;
  wire logic wreq, pwr, dwr, back, trp, irq;
  wire logic [1:0] tk;
  int num_errors, n_tests, cyc, np, nt, nb, nd, k;
  calb_exec calb_exec_i (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(a_q), .avs_read(rd_q),
    .avs_write(wr_q), .avs_writedata(wd_q), .avs_byteenable(4'hf), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .push_wr(pwr), .push_addr(paddr), .push_data(pdata),
    .dest_wr(dwr), .bp_ack(back), .trap(trp), .trap_kind(tk), .irq(irq));
  // 40 mhz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // pulses are one cycle wide, so count them at every edge; a hang ends the run
  always @(posedge ref_clk)
  begin
    np += (pwr === 1'b1);
    nt += (trp === 1'b1);
    nb += (back === 1'b1);
    nd += (dwr === 1'b1);
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      print_verdict();
    end
  end
  //----------------------------------------------------------------
  // bus and compare tasks
  //----------------------------------------------------------------
  // one access; the leading edge keeps a release and a new request apart
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    a_q <= a;
    wd_q <= d;
    wr_q <= w;
    rd_q <= ~w;
    @(posedge ref_clk);
    while (wreq !== 1'b0) @(posedge ref_clk);
    rdat = rdata;
    wr_q <= 1'b0;
    rd_q <= 1'b0;
  endtask
  task automatic same(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    same(rdat, exp);
  endtask
  function automatic logic [31:0] cm(input calb_pkg::calb_op_t op, input logic [31:0] f);
    return {27'h0, op} | 32'h200 | f;
  endfunction
  // load operands, start, then wait out the fixed execute latency
  task automatic ex(input logic [31:0] c, input logic [31:0] s, input logic [31:0] d);
    acc(1'b1, calb_pkg::OFS_SRC, s);
    acc(1'b1, calb_pkg::OFS_DST, d);
    acc(1'b1, calb_pkg::OFS_CMD, c);
    repeat (4) @(posedge ref_clk);
  endtask
  // bit operation: destination afterwards and the zero flag
  task automatic bt(input calb_pkg::calb_op_t op, input logic [31:0] s, input logic [31:0] d,
    input logic [31:0] ed, input logic z);
    ex(cm(op, 32'h0), s, d);
    rc(calb_pkg::OFS_DST, ed);
    acc(1'b0, calb_pkg::OFS_SR, 32'h0);
    same(rdat[2], z);
  endtask
  task automatic print_verdict();
    $display("errors %0d, checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  //----------------------------------------------------------------
  // test sequence
  //----------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    rd_q = 1'b0;
    wr_q = 1'b0;
    a_q = 8'h00;
    wd_q = 32'h0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    rc(calb_pkg::OFS_SR, 32'h2000);
    rc(8'h40, 32'h0);
    acc(1'b1, calb_pkg::OFS_IRQ_MASK, 32'h1);
    ex(cm(calb_pkg::OP_ADD_IMM, 32'h0), 32'h5, 32'h10);
    rc(calb_pkg::OFS_DST, 32'h15);
    same(irq, 32'h1);
    acc(1'b1, calb_pkg::OFS_IRQ_MASK, 32'h0);
    acc(1'b1, calb_pkg::OFS_IRQ_ST, 32'h7);
    rc(calb_pkg::OFS_IRQ_ST, 32'h0);
    ex(cm(calb_pkg::OP_ADD_QUICK, 32'h0), 32'h0, 32'h1);
    rc(calb_pkg::OFS_DST, 32'h9);
    same(irq, 32'h0);
    ex(32'(calb_pkg::OP_ADD_IMM), 32'h1, 32'h1234_56ff);
    rc(calb_pkg::OFS_DST, 32'h1234_5600);
    rc(calb_pkg::OFS_SR, 32'h2015);
    acc(1'b1, calb_pkg::OFS_SR, 32'h2010);
    ex(cm(calb_pkg::OP_ADD_X, 32'h0), 32'h3, 32'h4);
    rc(calb_pkg::OFS_DST, 32'h8);
    ex(cm(calb_pkg::OP_AND_IMM, 32'h0), 32'h0f0f, 32'hffff_00ff);
    rc(calb_pkg::OFS_DST, 32'h0000_000f);
    acc(1'b1, calb_pkg::OFS_SR, 32'h001f);
    ex(cm(calb_pkg::OP_AND_COND_BYTE, 32'h0), 32'h4, 32'h0);
    rc(calb_pkg::OFS_SR, 32'h0004);
    ex(cm(calb_pkg::OP_AND_SR, 32'h0), 32'h0, 32'h0);
    rc(calb_pkg::OFS_SR, 32'h0004);
    same(nt, 32'h1);
    same(tk, 32'h1);
    acc(1'b1, calb_pkg::OFS_SR, 32'h201f);
    ex(cm(calb_pkg::OP_AND_SR, 32'h0), 32'hfff3, 32'h0);
    rc(calb_pkg::OFS_SR, 32'h2013);
    ex(cm(calb_pkg::OP_ARITH_SHIFT_LEFT, 32'h0), 32'h3, 32'h1);
    rc(calb_pkg::OFS_DST, 32'h8);
    ex(cm(calb_pkg::OP_ARITH_SHIFT_RIGHT, 32'h10000), 32'h4, 32'h8000_0000);
    rc(calb_pkg::OFS_DST, 32'hf800_0000);
    ex(cm(calb_pkg::OP_ARITH_SHIFT_LEFT, 32'h20000), 32'h7, 32'h3);
    rc(calb_pkg::OFS_DST, 32'h6);
    acc(1'b1, calb_pkg::OFS_PC, 32'h100);
    ex(cm(calb_pkg::OP_BCC, 32'h0), 32'h10, 32'h0);
    rc(calb_pkg::OFS_PC, 32'h110);
    ex(cm(calb_pkg::OP_BCC, 32'h1000), 32'h10, 32'h0);
    rc(calb_pkg::OFS_PC, 32'h110);
    acc(1'b1, calb_pkg::OFS_PC, 32'h200);
    acc(1'b1, calb_pkg::OFS_SP, 32'h1000);
    ex(cm(calb_pkg::OP_BRANCH_TO_SUBROUTINE, 32'h0), 32'h20, 32'h0);
    rc(calb_pkg::OFS_PC, 32'h220);
    rc(calb_pkg::OFS_SP, 32'hffc);
    same(paddr, 32'hffc);
    same(pdata, 32'h200);
    same(np, 32'h1);
    k = nd;
    bt(calb_pkg::OP_BIT_TEST, 32'h4, 32'h10, 32'h10, 1'b0);
    same(nd, k);
    bt(calb_pkg::OP_BIT_CHANGE, 32'h4, 32'h10, 32'h0, 1'b0);
    bt(calb_pkg::OP_BIT_CLEAR, 32'h0, 32'h1, 32'h0, 1'b0);
    bt(calb_pkg::OP_BIT_SET, 32'h3, 32'h0, 32'h8, 1'b1);
    ex(cm(calb_pkg::OP_BREAKPOINT_INSTR, 32'h0), 32'h0, 32'h0);
    same(nb, 32'h1);
    same(tk, 32'h3);
    ex(cm(calb_pkg::OP_BOUNDS_CHECK, 32'h0), 32'd100, 32'd101);
    same(tk, 32'h2);
    ex(cm(calb_pkg::OP_BOUNDS_CHECK, 32'h0), 32'd100, 32'hffff);
    same(nt, 32'h4);
    ex(cm(calb_pkg::OP_BOUNDS_CHECK, 32'h0), 32'd100, 32'd50);
    same(nt, 32'h4);
    k = nd;
    ex(cm(calb_pkg::OP_COMPARE, 32'h0), 32'h5, 32'h5);
    rc(calb_pkg::OFS_DST, 32'h5);
    same(nd, k);
    acc(1'b0, calb_pkg::OFS_SR, 32'h0);
    same(rdat[2], 32'h1);
    print_verdict();
  end
endmodule
`default_nettype wire
